// >>> rtl/smpf_pkg.sv
// Package for the sector map parameter and factory state block.
// Assumes byte addresses on an 8-bit Wishbone address and 32-bit data.
package smpf_pkg;

	// Sector map dwords, byte addresses on the bus
	localparam logic [7:0]  SMPF_OFF_MAP64_RGN   = 8'ha4;
	localparam logic [7:0]  SMPF_OFF_MAP256_HDR  = 8'ha8;
	localparam logic [7:0]  SMPF_OFF_MAP256_RGN  = 8'hac;
	localparam logic [7:0]  SMPF_MAP_LAST        = 8'haf;
	localparam logic [7:0]  SMPF_ALT_SHIFT       = 8'h02;

	// Control and state registers
	localparam logic [7:0]  SMPF_OFF_CTRL        = 8'h00;
	localparam logic [7:0]  SMPF_OFF_STATUS1     = 8'h04;
	localparam logic [7:0]  SMPF_OFF_CFG1        = 8'h08;
	localparam logic [7:0]  SMPF_OFF_CFG2        = 8'h0c;
	localparam logic [7:0]  SMPF_OFF_CFG3        = 8'h10;
	localparam logic [7:0]  SMPF_OFF_CFG4        = 8'h14;
	localparam logic [7:0]  SMPF_OFF_PWD_LO      = 8'h18;
	localparam logic [7:0]  SMPF_OFF_PWD_HI      = 8'h1c;
	localparam logic [7:0]  SMPF_OFF_LOCK_IDX    = 8'h20;
	localparam logic [7:0]  SMPF_OFF_LOCK_DATA   = 8'h24;
	localparam logic [7:0]  SMPF_OFF_SCHEME      = 8'h28;
	localparam logic [7:0]  SMPF_OFF_UID_LO      = 8'h2c;
	localparam logic [7:0]  SMPF_OFF_UID_HI      = 8'h30;
	localparam logic [7:0]  SMPF_OFF_PARAM_ADDR  = 8'h34;
	localparam logic [7:0]  SMPF_OFF_PARAM_DATA  = 8'h38;
	localparam logic [7:0]  SMPF_OFF_OTP_IDX     = 8'h3c;
	localparam logic [7:0]  SMPF_OFF_OTP_DATA    = 8'h40;
	localparam logic [7:0]  SMPF_OFF_ARRAY_ADDR  = 8'h44;
	localparam logic [7:0]  SMPF_OFF_ARRAY_DATA  = 8'h48;

	// Field positions
	localparam int          SMPF_CTRL_RESTORE    = 0;
	localparam int          SMPF_PARAM_ALT_BIT   = 8;

	// Descriptor fields
	localparam logic [3:0]  SMPF_RSV_NIB         = 4'hf;
	localparam logic [23:0] SMPF_RGN_SIZE        = 24'h007fff;
	localparam logic [3:0]  SMPF_ET_64K          = 4'h2;
	localparam logic [3:0]  SMPF_ET_256K         = 4'h4;
	localparam logic [7:0]  SMPF_HDR_RSV         = 8'hff;
	localparam logic [7:0]  SMPF_HDR_RCNT        = 8'h00;
	localparam logic [7:0]  SMPF_HDR_CFGID       = 8'h05;
	localparam logic [5:0]  SMPF_HDR_LO_RSV      = 6'h3f;
	localparam logic [1:0]  SMPF_HDR_MAP_END     = 2'h3;

	// Delivery state
	localparam logic [7:0]  SMPF_STATUS1_DEF     = 8'h00;
	localparam logic [7:0]  SMPF_CFG123_DEF      = 8'h00;
	localparam logic [7:0]  SMPF_CFG4_DEF        = 8'h10;
	localparam logic [47:0] SMPF_PWD_DEF         = 48'hffff_ffff_ffff;
	localparam logic        SMPF_LOCK_DEF        = 1'b1;
	localparam logic [15:0] SMPF_SCHEME_DEF      = 16'hffff;
	localparam logic [7:0]  SMPF_ERASED          = 8'hff;
	localparam logic [9:0]  SMPF_OTP_RAND_BYTES  = 10'h010;
	localparam int          SMPF_SECTORS         = 128;

	// Pointer values after reset
	localparam logic [6:0]  SMPF_LOCK_IDX_RST    = 7'h00;
	localparam logic [8:0]  SMPF_PARAM_ADDR_RST  = 9'h000;
	localparam logic [9:0]  SMPF_OTP_IDX_RST     = 10'h000;
	localparam logic [22:0] SMPF_ARRAY_ADDR_RST  = 23'h000000;

endpackage : smpf_pkg

// >>> rtl/smpf_map_rom.sv
// Byte lookup into the tail of the sector map parameter table.
// Assumes a registered offset from the caller; pure combinational.
`timescale 1ns/1ps
`default_nettype none
module smpf_map_rom (
	input  wire logic [7:0] i_offset,
	input  wire logic       i_alt,
	output logic      [7:0] o_byte
);
	logic [7:0]  sfdp_off;
	logic [7:0]  rel;
	logic [31:0] dw [3];

	// Descriptor dwords built from fields
	assign dw[0] = {smpf_pkg::SMPF_RGN_SIZE, smpf_pkg::SMPF_RSV_NIB, smpf_pkg::SMPF_ET_64K};
	assign dw[1] = {smpf_pkg::SMPF_HDR_RSV, smpf_pkg::SMPF_HDR_RCNT, smpf_pkg::SMPF_HDR_CFGID,
	                smpf_pkg::SMPF_HDR_LO_RSV, smpf_pkg::SMPF_HDR_MAP_END};
	assign dw[2] = {smpf_pkg::SMPF_RGN_SIZE, smpf_pkg::SMPF_RSV_NIB, smpf_pkg::SMPF_ET_256K};

	// Alternate space sits two bytes above
	assign sfdp_off = i_alt ? 8'(i_offset - smpf_pkg::SMPF_ALT_SHIFT) : i_offset;
	assign rel      = 8'(sfdp_off - smpf_pkg::SMPF_OFF_MAP64_RGN);

	// Low byte at lowest offset
	always_comb begin
		o_byte = smpf_pkg::SMPF_ERASED;
		if (sfdp_off >= smpf_pkg::SMPF_OFF_MAP64_RGN && sfdp_off <= smpf_pkg::SMPF_MAP_LAST) begin
			o_byte = dw[rel[3:2]][rel[1:0]*8 +: 8];
		end
	end
endmodule : smpf_map_rom
`default_nettype wire

// >>> rtl/smpf_otp_src.sv
// Delivery contents of the one-time-programmable space.
// Assumes the random seed is a fixed value from the top.
`timescale 1ns/1ps
`default_nettype none
module smpf_otp_src (
	input  wire logic [9:0]   i_idx,
	input  wire logic [127:0] i_rand,
	output logic      [7:0]   o_byte
);
	// Random head, erased elsewhere
	always_comb begin
		o_byte = smpf_pkg::SMPF_ERASED;
		if (i_idx < smpf_pkg::SMPF_OTP_RAND_BYTES) begin
			o_byte = i_rand[i_idx[3:0]*8 +: 8];
		end
	end
endmodule : smpf_otp_src
`default_nettype wire

// >>> rtl/smpf_top.sv
// Sector map parameter tail and factory state, Wishbone slave.
// Assumes a classic Wishbone master on i_core_clk, synchronous reset.
//
// Operation
// - 64KB region size field is 7FFFh, 256-byte units minus one.
// - 64KB region supports only erase type 2.
// - 256KB header has region count 00h and configuration id 05h.
// - 256KB header bits 31:24 read as ones.
// - 256KB header sets map descriptor and end descriptor bits.
// - 256KB region size field is 7FFFh, 256-byte units minus one.
// - 256KB region supports only erase type 3.
// - Main array reads FFh everywhere at delivery.
// - OTP holds random first 16 bytes, FFh elsewhere.
// - Unique id space holds a 64-bit device number.
// - Persistent status one reads 00h at delivery.
// - Persistent configuration one, two, three read 00h at delivery.
// - Persistent configuration four reads 10h at delivery.
// - Password holds all ones at delivery.
// - Every per-sector lock bit is one at delivery.
// - Protection scheme register reads FFFFh at delivery.
// - Erase type support bit: one supported, zero not.
`timescale 1ns/1ps
`default_nettype none
module smpf_top #(
	parameter logic [63:0]  UNIQUE_ID = 64'h0123_4567_89ab_cdef,  // Arbitrary value
	parameter logic [127:0] OTP_RAND  = 128'h5a3c_96e1_0f72_b4d8_1e6a_c395_27f0_8b4d
) (
	input  wire logic        i_core_clk,
	input  wire logic        i_srst,
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [7:0]  i_wb_adr,
	input  wire logic [3:0]  i_wb_sel,
	input  wire logic [31:0] i_wb_dat,
	output logic      [31:0] o_wb_dat,
	output logic             o_wb_ack
);
	logic [7:0]   status_one_persistent_q;
	logic [7:0]   cfg1_q;
	logic [7:0]   cfg2_q;
	logic [7:0]   cfg3_q;
	logic [7:0]   cfg4_q;
	logic [47:0]  password_q;
	logic [6:0]   lock_idx_q;
	logic [127:0] per_sector_persistent_lock_q;
	logic [15:0]  sector_protection_scheme_q;
	logic [8:0]   param_addr_q;
	logic [9:0]   otp_idx_q;
	logic [22:0]  array_addr_q;
	logic [31:0]  rd_d;
	logic [31:0]  wmask;
	logic [7:0]   adr;
	logic         req;
	logic         wr;
	logic         restore;
	logic [7:0]   param_byte;
	logic [7:0]   otp_byte;
	logic [31:0]  map_dw [3];

	// Request decode; word aligned, low bits ignored
	assign adr     = {i_wb_adr[7:2], 2'b00};
	assign req     = i_wb_cyc && i_wb_stb && !o_wb_ack;
	assign wr      = req && i_wb_we;
	assign wmask   = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
	assign restore = wr && adr == smpf_pkg::SMPF_OFF_CTRL && i_wb_sel[0]
	                 && i_wb_dat[smpf_pkg::SMPF_CTRL_RESTORE];

	// Byte-lane merge for writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
	                                      input logic [31:0] m);
		merge = (old & ~m) | (nw & m);
	endfunction : merge

	// Fixed map dwords for the word port; the byte port builds its own copy
	assign map_dw[0] = {smpf_pkg::SMPF_RGN_SIZE, smpf_pkg::SMPF_RSV_NIB, smpf_pkg::SMPF_ET_64K};
	assign map_dw[1] = {smpf_pkg::SMPF_HDR_RSV, smpf_pkg::SMPF_HDR_RCNT, smpf_pkg::SMPF_HDR_CFGID,
	                    smpf_pkg::SMPF_HDR_LO_RSV, smpf_pkg::SMPF_HDR_MAP_END};
	assign map_dw[2] = {smpf_pkg::SMPF_RGN_SIZE, smpf_pkg::SMPF_RSV_NIB, smpf_pkg::SMPF_ET_256K};

	// Byte-wise parameter reader
	smpf_map_rom u_map_rom (
		.i_offset (param_addr_q[7:0]),
		.i_alt    (param_addr_q[smpf_pkg::SMPF_PARAM_ALT_BIT]),
		.o_byte   (param_byte)
	);

	// Delivery contents of the OTP space
	smpf_otp_src u_otp_src (
		.i_idx  (otp_idx_q),
		.i_rand (OTP_RAND),
		.o_byte (otp_byte)
	);

	// Status one; restore and reset share the delivery value
	always_ff @(posedge i_core_clk) begin
		if (i_srst || restore) begin
			status_one_persistent_q <= smpf_pkg::SMPF_STATUS1_DEF;
		end else if (wr && adr == smpf_pkg::SMPF_OFF_STATUS1) begin
			status_one_persistent_q <= 8'(merge({24'h0, status_one_persistent_q}, i_wb_dat, wmask));
		end
	end

	// Configuration one to three
	always_ff @(posedge i_core_clk) begin
		if (i_srst || restore) begin
			cfg1_q <= smpf_pkg::SMPF_CFG123_DEF;
			cfg2_q <= smpf_pkg::SMPF_CFG123_DEF;
			cfg3_q <= smpf_pkg::SMPF_CFG123_DEF;
		end else if (wr) begin
			if (adr == smpf_pkg::SMPF_OFF_CFG1) begin
				cfg1_q <= 8'(merge({24'h0, cfg1_q}, i_wb_dat, wmask));
			end
			if (adr == smpf_pkg::SMPF_OFF_CFG2) begin
				cfg2_q <= 8'(merge({24'h0, cfg2_q}, i_wb_dat, wmask));
			end
			if (adr == smpf_pkg::SMPF_OFF_CFG3) begin
				cfg3_q <= 8'(merge({24'h0, cfg3_q}, i_wb_dat, wmask));
			end
		end
	end

	// Configuration four
	always_ff @(posedge i_core_clk) begin
		if (i_srst || restore) begin
			cfg4_q <= smpf_pkg::SMPF_CFG4_DEF;
		end else if (wr && adr == smpf_pkg::SMPF_OFF_CFG4) begin
			cfg4_q <= 8'(merge({24'h0, cfg4_q}, i_wb_dat, wmask));
		end
	end

	// Password, split over two words
	always_ff @(posedge i_core_clk) begin
		if (i_srst || restore) begin
			password_q <= smpf_pkg::SMPF_PWD_DEF;
		end else if (wr && adr == smpf_pkg::SMPF_OFF_PWD_LO) begin
			password_q[31:0] <= merge(password_q[31:0], i_wb_dat, wmask);
		end else if (wr && adr == smpf_pkg::SMPF_OFF_PWD_HI) begin
			password_q[47:32] <= 16'(merge({16'h0, password_q[47:32]}, i_wb_dat, wmask));
		end
	end

	// Protection scheme register
	always_ff @(posedge i_core_clk) begin
		if (i_srst || restore) begin
			sector_protection_scheme_q <= smpf_pkg::SMPF_SCHEME_DEF;
		end else if (wr && adr == smpf_pkg::SMPF_OFF_SCHEME) begin
			sector_protection_scheme_q <= 16'(merge({16'h0, sector_protection_scheme_q}, i_wb_dat, wmask));
		end
	end

	// Lock index selects one sector for the data port
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			lock_idx_q <= smpf_pkg::SMPF_LOCK_IDX_RST;
		end else if (wr && adr == smpf_pkg::SMPF_OFF_LOCK_IDX && i_wb_sel[0]) begin
			lock_idx_q <= i_wb_dat[6:0];
		end
	end

	// One lock bit per sector; only the indexed bit takes a write
	for (genvar g = 0; g < smpf_pkg::SMPF_SECTORS; g++) begin : g_lock
		always_ff @(posedge i_core_clk) begin
			if (i_srst || restore) begin
				per_sector_persistent_lock_q[g] <= smpf_pkg::SMPF_LOCK_DEF;
			end else if (wr && adr == smpf_pkg::SMPF_OFF_LOCK_DATA && i_wb_sel[0]
			             && lock_idx_q == 7'(g)) begin
				per_sector_persistent_lock_q[g] <= i_wb_dat[0];
			end
		end
	end

	// Pointers into the parameter, OTP and array spaces
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			param_addr_q <= smpf_pkg::SMPF_PARAM_ADDR_RST;
			otp_idx_q    <= smpf_pkg::SMPF_OTP_IDX_RST;
			array_addr_q <= smpf_pkg::SMPF_ARRAY_ADDR_RST;
		end else if (wr) begin
			if (adr == smpf_pkg::SMPF_OFF_PARAM_ADDR) begin
				param_addr_q <= 9'(merge({23'h0, param_addr_q}, i_wb_dat, wmask));
			end
			if (adr == smpf_pkg::SMPF_OFF_OTP_IDX) begin
				otp_idx_q <= 10'(merge({22'h0, otp_idx_q}, i_wb_dat, wmask));
			end
			if (adr == smpf_pkg::SMPF_OFF_ARRAY_ADDR) begin
				array_addr_q <= 23'(merge({9'h0, array_addr_q}, i_wb_dat, wmask));
			end
		end
	end

	// Read mux; unmapped reads return zero
	always_comb begin
		rd_d = 32'h00000000;
		case (adr)
			smpf_pkg::SMPF_OFF_MAP64_RGN:  rd_d = map_dw[0];
			smpf_pkg::SMPF_OFF_MAP256_HDR: rd_d = map_dw[1];
			smpf_pkg::SMPF_OFF_MAP256_RGN: rd_d = map_dw[2];
			smpf_pkg::SMPF_OFF_STATUS1:    rd_d = {24'h0, status_one_persistent_q};
			smpf_pkg::SMPF_OFF_CFG1:       rd_d = {24'h0, cfg1_q};
			smpf_pkg::SMPF_OFF_CFG2:       rd_d = {24'h0, cfg2_q};
			smpf_pkg::SMPF_OFF_CFG3:       rd_d = {24'h0, cfg3_q};
			smpf_pkg::SMPF_OFF_CFG4:       rd_d = {24'h0, cfg4_q};
			smpf_pkg::SMPF_OFF_PWD_LO:     rd_d = password_q[31:0];
			smpf_pkg::SMPF_OFF_PWD_HI:     rd_d = {16'h0, password_q[47:32]};
			smpf_pkg::SMPF_OFF_LOCK_IDX:   rd_d = {25'h0, lock_idx_q};
			smpf_pkg::SMPF_OFF_LOCK_DATA:  rd_d = {31'h0, per_sector_persistent_lock_q[lock_idx_q]};
			smpf_pkg::SMPF_OFF_SCHEME:     rd_d = {16'h0, sector_protection_scheme_q};
			smpf_pkg::SMPF_OFF_UID_LO:     rd_d = UNIQUE_ID[31:0];
			smpf_pkg::SMPF_OFF_UID_HI:     rd_d = UNIQUE_ID[63:32];
			smpf_pkg::SMPF_OFF_PARAM_ADDR: rd_d = {23'h0, param_addr_q};
			smpf_pkg::SMPF_OFF_PARAM_DATA: rd_d = {24'h0, param_byte};
			smpf_pkg::SMPF_OFF_OTP_IDX:    rd_d = {22'h0, otp_idx_q};
			smpf_pkg::SMPF_OFF_OTP_DATA:   rd_d = {24'h0, otp_byte};
			smpf_pkg::SMPF_OFF_ARRAY_ADDR: rd_d = {9'h0, array_addr_q};
			smpf_pkg::SMPF_OFF_ARRAY_DATA: rd_d = {24'h0, smpf_pkg::SMPF_ERASED};
			default:                       rd_d = 32'h00000000;
		endcase
	end

	// Ack one cycle after the request, then drop for a cycle
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			o_wb_ack <= 1'b0;
		end else begin
			o_wb_ack <= req;
		end
	end

	// Read data captured with the ack; zero for writes
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			o_wb_dat <= 32'h00000000;
		end else if (req && !i_wb_we) begin
			o_wb_dat <= rd_d;
		end else if (req) begin
			o_wb_dat <= 32'h00000000;
		end
	end
endmodule : smpf_top
`default_nettype wire

// >>> verif/smpf_assertions.sv
// Port checker for the sector map and delivery state slave.
// Assumes it is bound to smpf_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module smpf_assertions #(
	parameter logic [63:0] UNIQUE_ID = 64'h0
) (
	input wire logic        i_core_clk,
	input wire logic        i_srst,
	input wire logic        i_wb_cyc,
	input wire logic        i_wb_stb,
	input wire logic        i_wb_we,
	input wire logic [7:0]  i_wb_adr,
	input wire logic [3:0]  i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	input wire logic [31:0] o_wb_dat,
	input wire logic        o_wb_ack
);
	// Request taken on this edge; a held request is not re-taken in its ack cycle
	logic tk;
	assign tk = i_wb_cyc && i_wb_stb && !o_wb_ack;
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_srst);

	ack_one_cycle_a: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack held past one cycle");
	ack_after_take_a: assert property (tk |=> o_wb_ack) else $error("ack missing after request");
	ack_has_cause_a: assert property (o_wb_ack |-> $past(tk)) else $error("ack without request");
	write_data_a: assert property (tk && i_wb_we |=> o_wb_dat == 32'h0) else $error("write ack data not zero");
	map64_word_a: assert property (
		tk && !i_wb_we && i_wb_adr[7:2] == 6'h29 |=> o_wb_dat == 32'h007ffff2) else $error("64k region word wrong");
	hdr256_word_a: assert property (
		tk && !i_wb_we && i_wb_adr[7:2] == 6'h2a |=> o_wb_dat == 32'hff0005ff) else $error("256k header word wrong");
	map256_word_a: assert property (
		tk && !i_wb_we && i_wb_adr[7:2] == 6'h2b |=> o_wb_dat == 32'h007ffff4) else $error("256k region word wrong");
	array_erased_a: assert property (
		tk && !i_wb_we && i_wb_adr[7:2] == 6'h12 |=> o_wb_dat[7:0] == 8'hff) else $error("array byte not erased");
	uid_low_a: assert property (
		tk && !i_wb_we && i_wb_adr[7:2] == 6'h0b |=> o_wb_dat == UNIQUE_ID[31:0]) else $error("uid low wrong");
	uid_high_a: assert property (
		tk && !i_wb_we && i_wb_adr[7:2] == 6'h0c |=> o_wb_dat == UNIQUE_ID[63:32]) else $error("uid high wrong");
endmodule : smpf_assertions

bind smpf_top smpf_assertions #(.UNIQUE_ID(UNIQUE_ID)) u_smpf_assertions (
	.i_core_clk(i_core_clk), .i_srst(i_srst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
	.i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
	.o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack));
`default_nettype wire

// >>> verif/smpf_host_model.sv
// Host side model: a classic Wishbone master issuing single cycles.
// Assumes the bench calls xfer and that the slave acks each request.
`timescale 1ns/1ps
`default_nettype none
module smpf_host_model (
	input  wire logic        i_core_clk,
	input  wire logic        i_ack,
	input  wire logic [31:0] i_rdat,
	output logic             o_cyc,
	output logic             o_stb,
	output logic             o_we,
	output logic      [7:0]  o_adr,
	output logic      [3:0]  o_sel,
	output logic      [31:0] o_dat
);
	// Idle bus at time zero
	initial begin
		o_cyc = 1'b0;
		o_stb = 1'b0;
		o_we  = 1'b0;
		o_adr = 8'h00;
		o_sel = 4'h0;
		o_dat = 32'h0;
	end

	// Released address and data are inverted so stale values never look valid
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [31:0] r);
		@(posedge i_core_clk);
		{o_cyc, o_stb, o_we, o_adr, o_dat, o_sel} <= {2'b11, w, a, d, s};
		do @(posedge i_core_clk); while (i_ack !== 1'b1);
		r = i_rdat;
		{o_cyc, o_stb, o_adr, o_dat} <= {2'b00, ~a, ~d};
		@(posedge i_core_clk);
	endtask : xfer
endmodule : smpf_host_model
`default_nettype wire

// >>> verif/test_smpf_top.sv
// Self-checking bench for the sector map and delivery state slave.
// Assumes the checker binds itself and the host model drives the bus.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
	$display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module test_smpf_top;
	localparam logic [63:0]  UID = 64'h1122_3344_5566_7788;  // Arbitrary value
	localparam logic [127:0] RND = 128'hf0e1_d2c3_b4a5_9687_7869_5a4b_3c2d_1e0f;
	logic i_core_clk, i_srst, cyc, stb, we, ack;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat;
	int bad_count = 0, samples_checked = 0, cycles = 0;

	smpf_top #(.UNIQUE_ID(UID), .OTP_RAND(RND)) u_smpf_top (.i_core_clk(i_core_clk), .i_srst(i_srst),
		.i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
		.o_wb_dat(rdat), .o_wb_ack(ack));
	smpf_host_model u_smpf_host_model (.i_core_clk(i_core_clk), .i_ack(ack), .i_rdat(rdat), .o_cyc(cyc),
		.o_stb(stb), .o_we(we), .o_adr(adr), .o_sel(sel), .o_dat(wdat));

	// 200 MHz clock
	initial begin
		i_core_clk = 1'b0;
		forever #2.5 i_core_clk = ~i_core_clk;
	end

	// Hang guard, well above the roughly 140 transfers planned
	always @(posedge i_core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			end_sim();
		end
	end

	task automatic end_sim();
		if (bad_count == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : end_sim

	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		u_smpf_host_model.xfer(1'b0, a, 32'h0, 4'hf, r);
	endtask : rd

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		u_smpf_host_model.xfer(1'b1, a, d, s, r);
	endtask : wr

	// Map words, write to read-only place, unmapped address
	task automatic t_map();
		logic [31:0] r;
		wr(8'ha4, 32'h0, 4'hf);
		rd(8'ha4, r); `CHK("map64", 32'h007ffff2, r)
		rd(8'ha8, r); `CHK("hdr256", 32'hff0005ff, r)
		rd(8'hac, r); `CHK("map256", 32'h007ffff4, r)
		rd(8'hf0, r); `CHK("unmapped", 32'h0, r)
	endtask : t_map

	// Byte view of the map, both spaces, one byte past each end
	task automatic t_param();
		logic [31:0] mp [3] = '{32'h007ffff2, 32'hff0005ff, 32'h007ffff4};
		logic [31:0] r;
		logic [7:0] o, e;
		for (int i = 8'ha3; i <= 8'hb0; i++) begin
			o = 8'(i);
			e = (o < 8'ha4 || o > 8'haf) ? 8'hff : mp[(o - 8'ha4) >> 2][o[1:0]*8 +: 8];
			wr(8'h34, {24'h0, o}, 4'hf);
			rd(8'h38, r); `CHK("param", e, r[7:0])
			wr(8'h34, {23'h0, 1'b1, 8'(o + 8'h02)}, 4'hf);
			rd(8'h38, r); `CHK("param_alt", e, r[7:0])
		end
	endtask : t_param

	// Delivery state of every register, first and last lock, OTP and array
	task automatic t_defaults();
		logic [7:0] ad [12] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h28, 8'h2c, 8'h30, 8'h48, 8'h48};
		logic [31:0] ex [12] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h10, 32'hffffffff, 32'hffff, 32'hffff,
			UID[31:0], UID[63:32], 32'hff, 32'hff};
		logic [31:0] r;
		for (int i = 0; i < 12; i++) begin
			if (i == 11) wr(8'h44, 32'h007fffff, 4'hf);
			rd(ad[i], r); `CHK("default", ex[i], r)
		end
		for (int k = 0; k < 128; k += 127) begin
			wr(8'h20, 32'(k), 4'hf);
			rd(8'h24, r); `CHK("lock", 1'b1, r[0])
		end
		for (int k = 0; k < 18; k++) begin
			wr(8'h3c, (k == 17) ? 32'h3ff : 32'(k), 4'hf);
			rd(8'h40, r); `CHK("otp", (k < 16) ? RND[k*8 +: 8] : 8'hff, r[7:0])
		end
	endtask : t_defaults

	// Byte lanes, then restore of the delivery state by command
	task automatic t_restore();
		logic [31:0] r;
		wr(8'h04, 32'h5a, 4'hf);
		wr(8'h04, 32'ha5, 4'h0);
		rd(8'h04, r); `CHK("sel_gate", 32'h5a, r)
		wr(8'h14, 32'h0, 4'hf);
		wr(8'h0c, 32'h77, 4'hf);
		wr(8'h1c, 32'h0, 4'h1);
		rd(8'h1c, r); `CHK("sel_lane", 32'hff00, r)
		wr(8'h18, 32'h0, 4'hf);
		wr(8'h28, 32'h0, 4'hf);
		wr(8'h20, 32'h5, 4'hf);
		wr(8'h24, 32'h0, 4'hf);
		rd(8'h24, r); `CHK("lock_clr", 1'b0, r[0])
		wr(8'h00, 32'h1, 4'h1);
		rd(8'h04, r); `CHK("rst_status", 32'h0, r)
		rd(8'h14, r); `CHK("rst_cfg4", 32'h10, r)
		rd(8'h0c, r); `CHK("rst_cfg2", 32'h0, r)
		rd(8'h1c, r); `CHK("rst_pwd_hi", 32'hffff, r)
		rd(8'h18, r); `CHK("rst_pwd", 32'hffffffff, r)
		rd(8'h28, r); `CHK("rst_scheme", 32'hffff, r)
		rd(8'h24, r); `CHK("rst_lock", 1'b1, r[0])
	endtask : t_restore

	// Mid-run reset; last read leaves nonzero data so a stale bus shows up
	task automatic t_reset();
		logic [31:0] r;
		wr(8'h08, 32'h33, 4'hf);
		wr(8'h1c, 32'h1234, 4'hf);
		wr(8'h34, 32'h1a4, 4'hf);
		rd(8'h14, r);
		@(posedge i_core_clk);
		i_srst <= 1'b1;
		repeat (2) @(posedge i_core_clk);
		i_srst <= 1'b0;
		@(posedge i_core_clk);
		`CHK("srst_ack", 1'b0, ack)
		`CHK("srst_dat", 32'h0, rdat)
		rd(8'h08, r); `CHK("srst_cfg1", 32'h0, r)
		rd(8'h1c, r); `CHK("srst_pwd_hi", 32'hffff, r)
		rd(8'h34, r); `CHK("srst_param_ptr", 32'h0, r)
	endtask : t_reset

	// Reset, scenarios, verdict
	initial begin
		i_srst = 1'b1;
		repeat (5) @(posedge i_core_clk);
		i_srst <= 1'b0;
		@(posedge i_core_clk);
		t_map();
		t_param();
		t_defaults();
		t_restore();
		t_reset();
		end_sim();
	end
endmodule : test_smpf_top
`default_nettype wire
